// File: bench/nfc_front_end_tb_top.sv
// self-checking testbench of the flash command front end
`timescale 1ns/1ns
`default_nettype none
module nfc_front_end_tb_top
  import nfc_pkg::*;
;
  // ****************************************
  // stimulus, model and checking
  // ****************************************
  logic clk = 0, rst_n = 0, frst_n = 1, ce_n = 1, oe_n = 1, we_n = 1;
  logic stall = 0, fail = 0, kick = 0;
  logic [25:0] addr = 26'h0;
  logic [15:0] dq = 16'h0, v;
  logic [43:0] e;
  wire logic [15:0] dq_o, rdata, pdata;
  wire logic [25:0] aaddr, paddr;
  wire logic [1:0] pop_op;
  wire logic oe, pvalid, pready, done, err, abort, busy;
  int error_cnt = 0, checks = 0;
  initial
  begin
    forever #5 clk = ~clk;
  end
  nfc_front_end i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .flash_rst_n_i(frst_n),
    .chip_sel_n_i(ce_n), .out_en_n_i(oe_n), .write_en_n_i(we_n), .addr_i(addr), .dq_i(dq),
    .dq_o(dq_o), .dq_oe_o(oe), .array_addr_o(aaddr), .array_rdata_i(rdata),
    .id_rdata_i(16'h1234), .query_rdata_i(8'h5A), .prog_valid_o(pvalid), .prog_ready_i(pready),
    .prog_op_o(pop_op), .prog_addr_o(paddr), .prog_data_o(pdata), .array_done_i(done),
    .array_error_i(err), .array_abort_o(abort), .busy_o(busy));
  nfc_prog_model i_prog (.core_clk_i(clk), .stall_i(stall), .fail_i(fail), .kick_i(kick),
    .prog_valid_i(pvalid), .prog_ready_o(pready), .prog_op_i(pop_op), .prog_addr_i(paddr),
    .prog_data_i(pdata), .array_addr_i(aaddr), .array_rdata_o(rdata), .array_done_o(done),
    .array_error_o(err), .array_abort_i(abort));
  task automatic complete_run();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [43:0] s, input logic [43:0] x);
    checks++;
    if (s !== x)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, s, x);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [25:0] a, input logic [15:0] d);
    {addr, dq, ce_n, we_n} <= {a, d, 2'b00};
    cyc(5);
    {ce_n, we_n} <= 2'b11;
    cyc(5);
  endtask
  task automatic rd(input logic [25:0] a, output logic [15:0] r);
    {addr, ce_n, oe_n} <= {a, 2'b00};
    cyc(7);
    #1 r = oe === 1'b1 ? dq_o : 16'hDEAD;
    cyc(1);
    {ce_n, oe_n} <= 2'b11;
    cyc(5);
  endtask
  task automatic pop(output logic [43:0] r);
    int n;
    n = 0;
    while (i_prog.log_q.size() == 0 && n < 300)
    begin
      cyc(1);
      n++;
    end
    if (n == 300)
    begin
      error_cnt++;
      complete_run();
    end
    else
      r = i_prog.log_q.pop_front();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 500)
    begin
      cyc(1);
      n++;
    end
    if (n == 500)
    begin
      error_cnt++;
      complete_run();
    end
  endtask
  task automatic t_reset();
    rd(26'h123, v);
    chk(v, 16'hA486);
    wr(26'h0, 16'h70);
    rd(26'h0, v);
    chk(v[7:0], STATUS_RESET);
  endtask
  task automatic t_modes();
    wr(26'h3FF0001, 16'h90);
    rd(26'h10, v);
    chk(v, 16'h1234);
    wr(26'h2000002, 16'h98);
    rd(26'h10, v);
    chk(v[7:0], 8'h5A);
    wr(26'h0155555, 16'hFF);
    rd(26'h10, v);
    chk(v, 16'hA5B5);
    oe_n <= 1'b0;
    cyc(6);
    #1 chk(oe, 1'b0);
    cyc(1);
    oe_n <= 1'b1;
  endtask
  task automatic t_word(input logic f);
    fail <= f;
    wr(26'h0, 16'h40);
    wr(26'h0ABCDE, 16'h5555);
    pop(e);
    chk(e, {OP_WORD, 26'h0ABCDE, 16'h5555});
    wr(26'h0, 16'hFF);
    rd(26'h0, v);
    chk(v[7:0], 8'h00);
    wait_idle();
    rd(26'h0, v);
    chk(v[7:0], f ? 8'h90 : 8'h80);
    wr(26'h0, 16'h50);
    rd(26'h0, v);
    chk(v[7:0], 8'h80);
    wr(26'h0, 16'hFF);
    rd(26'h1, v);
    chk(v, 16'hA5A4);
    fail <= 1'b0;
  endtask
  task automatic t_seq();
    wr(26'h0, 16'hE8);
    wr(26'h0, BUF_MAX_WORDS);
    rd(26'h0, v);
    chk(v[7:0], 8'hB0);
    wr(26'h0, 16'h50);
    wr(26'h0, 16'hE8);
    wr(26'h0, 16'h0);
    wr(26'h7, 16'h1234);
    pop(e);
    chk(e, {OP_BUF_LOAD, 26'h7, 16'h1234});
    wr(26'h7, 16'hFF);
    rd(26'h0, v);
    chk(v[7:0], 8'hB0);
    wr(26'h0, 16'h50);
    wr(26'h0, 16'h80);
    wr(26'h0, 16'h70);
    rd(26'h0, v);
    chk(v[7:0], 8'hB0);
    wr(26'h0, 16'h50);
    wr(26'h0, 16'hFF);
  endtask
  task automatic t_buf();
    stall <= 1'b1;
    wr(26'h0, 16'hE8);
    wr(26'h0, 16'h3);
    for (int i = 0; i < 4; i++)
      wr(26'h40 + i, 16'h1111 * i);
    stall <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      pop(e);
      chk(e, {OP_BUF_LOAD, 26'(26'h40 + i), 16'(16'h1111 * i)});
    end
    wr(26'h40, 16'hD0);
    pop(e);
    chk(e[43:42], OP_BUF_GO);
    wait_idle();
    wr(26'h0, 16'hFF);
  endtask
  task automatic t_fact();
    wr(26'h0, 16'h80);
    wr(26'h0123456, 16'hD0);
    pop(e);
    chk(e, {OP_FACTORY, 26'h0123456, 16'h00D0});
    wr(26'h5, 16'hFF);
    pop(e);
    chk(e, {OP_FACTORY, 26'h5, 16'h00FF});
    kick <= 1'b1;
    cyc(1);
    kick <= 1'b0;
    wr(26'h0, 16'hFF);
    rd(26'h2, v);
    chk(v, 16'hA5A7);
  endtask
  task automatic t_rst();
    wr(26'h0, 16'h40);
    wr(26'h9, 16'h0F0F);
    pop(e);
    {frst_n, ce_n, oe_n} <= 3'b000;
    cyc(6);
    #1;
    chk(abort, 1'b1);
    chk(oe, 1'b0);
    chk(busy, 1'b0);
    cyc(1);
    {frst_n, ce_n, oe_n} <= 3'b111;
    cyc(5);
    rd(26'h3, v);
    chk(v, 16'hA5A6);
    wr(26'h0, 16'h70);
    rd(26'h0, v);
    chk(v[7:0], STATUS_RESET);
  endtask
  initial
  begin
    cyc(20);
    rst_n <= 1'b1;
    cyc(5);
    t_reset();
    t_modes();
    t_word(1'b0);
    t_word(1'b1);
    t_seq();
    t_buf();
    t_fact();
    t_rst();
    complete_run();
  end
endmodule
`default_nettype wire

// File: bench/nfc_prog_model.sv
// programmer and array model behind the program request port
`timescale 1ns/1ns
`default_nettype none
module nfc_prog_model
  import nfc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic stall_i,
  input wire logic fail_i,
  input wire logic kick_i,
  input wire logic prog_valid_i,
  output logic prog_ready_o,
  input wire logic [OP_W-1:0] prog_op_i,
  input wire logic [25:0] prog_addr_i,
  input wire logic [DQ_W-1:0] prog_data_i,
  input wire logic [25:0] array_addr_i,
  output logic [DQ_W-1:0] array_rdata_o,
  output logic array_done_o,
  output logic array_error_o,
  input wire logic array_abort_i
);
  // ****************************************
  // accepted requests and run timer
  // ****************************************
  logic [43:0] log_q[$];
  int timer_reg = 0;
  assign prog_ready_o = !stall_i;
  assign array_rdata_o = array_addr_i[15:0] ^ 16'hA5A5;
  always @(posedge core_clk_i)
  begin
    array_done_o <= kick_i || timer_reg == 1;
    array_error_o <= fail_i && timer_reg == 1;
    if (array_abort_i)
      timer_reg <= 0;
    else if (prog_valid_i && prog_ready_o && (prog_op_i == OP_WORD || prog_op_i == OP_BUF_GO))
      timer_reg <= 40;
    else if (timer_reg > 0)
      timer_reg <= timer_reg - 1;
    if (prog_valid_i && prog_ready_o)
      log_q.push_back({prog_op_i, prog_addr_i, prog_data_i});
  end
endmodule
`default_nettype wire

// File: design/nfc_fifo.sv
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module nfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = (count_reg != FULL_CNT);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge core_clk_i)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || flush_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : PTR_W'(wr_ptr_reg + 1'b1);
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : PTR_W'(rd_ptr_reg + 1'b1);
      end
      if (push && !pop)
      begin
        count_reg <= CNT_W'(count_reg + 1'b1);
      end
      else if (pop && !push)
      begin
        count_reg <= CNT_W'(count_reg - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

// File: design/nfc_front_end.sv
// command front end and reset and standby control of a parallel flash
`timescale 1ns/1ns
`default_nettype none
module nfc_front_end
  import nfc_pkg::*;
#(
  parameter int ADDR_W = 26
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic flash_rst_n_i,
  input wire logic chip_sel_n_i,
  input wire logic out_en_n_i,
  input wire logic write_en_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic [ADDR_W-1:0] array_addr_o,
  input wire logic [DQ_W-1:0] array_rdata_i,
  input wire logic [DQ_W-1:0] id_rdata_i,
  input wire logic [7:0] query_rdata_i,
  output logic prog_valid_o,
  input wire logic prog_ready_i,
  output logic [OP_W-1:0] prog_op_o,
  output logic [ADDR_W-1:0] prog_addr_o,
  output logic [DQ_W-1:0] prog_data_o,
  input wire logic array_done_i,
  input wire logic array_error_i,
  output logic array_abort_o,
  output logic busy_o
);
  localparam int PIN_W = 4 + ADDR_W + DQ_W;
  localparam int ENT_W = OP_W + ADDR_W + DQ_W;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [PIN_W-1:0] pin_s1_reg;
  logic [PIN_W-1:0] pin_s2_reg;
  logic pin_rst_n;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic [ADDR_W-1:0] addr_s;
  logic [DQ_W-1:0] dq_s;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_s1_reg <= {4'h7, {(PIN_W-4){1'b0}}};
      pin_s2_reg <= {4'h7, {(PIN_W-4){1'b0}}};
    end
    else
    begin
      pin_s1_reg <= {flash_rst_n_i, chip_sel_n_i, out_en_n_i, write_en_n_i, addr_i, dq_i};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign {pin_rst_n, ce_n, oe_n, we_n, addr_s, dq_s} = pin_s2_reg;

  // ****************************************
  // write cycle capture
  // ****************************************
  logic wr_act;
  logic wr_act_reg;
  logic wr_end;
  logic [ADDR_W-1:0] cap_addr_reg;
  logic [DQ_W-1:0] cap_data_reg;
  logic pend_valid_reg;
  logic [ADDR_W-1:0] pend_addr_reg;
  logic [DQ_W-1:0] pend_data_reg;
  logic fifo_in_ready;
  logic cmd_take;

  assign wr_act = !ce_n && !we_n && oe_n && pin_rst_n;
  // first of the two strobes to rise ends the cycle
  assign wr_end = wr_act_reg && !wr_act;
  assign cmd_take = pend_valid_reg && fifo_in_ready && pin_rst_n;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || !pin_rst_n)
    begin
      wr_act_reg <= 1'b0;
      cap_addr_reg <= '0;
      cap_data_reg <= '0;
    end
    else
    begin
      wr_act_reg <= wr_act;
      if (wr_act)
      begin
        cap_addr_reg <= addr_s;
        cap_data_reg <= dq_s;
      end
    end
  end

  // a write landing while the previous one still waits is dropped
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || !pin_rst_n)
    begin
      pend_valid_reg <= 1'b0;
      pend_addr_reg <= '0;
      pend_data_reg <= '0;
    end
    else if (wr_end && (!pend_valid_reg || cmd_take))
    begin
      pend_valid_reg <= 1'b1;
      pend_addr_reg <= cap_addr_reg;
      pend_data_reg <= cap_data_reg;
    end
    else if (cmd_take)
    begin
      pend_valid_reg <= 1'b0;
    end
  end

  // ****************************************
  // command interpreter
  // ****************************************
  nfc_state_t state_reg;
  nfc_state_t state_next;
  nfc_rmode_t rmode_reg;
  nfc_rmode_t rmode_next;
  logic [BUF_CNT_W-1:0] buf_cnt_reg;
  logic [BUF_CNT_W-1:0] buf_cnt_next;
  logic busy_reg;
  logic push_en;
  logic [OP_W-1:0] push_op;
  logic set_busy;
  logic seq_err;
  logic clr_err;
  logic [7:0] code;

  assign code = pend_data_reg[7:0];

  always_comb
  begin
    state_next = state_reg;
    rmode_next = rmode_reg;
    buf_cnt_next = buf_cnt_reg;
    push_en = 1'b0;
    push_op = OP_WORD;
    set_busy = 1'b0;
    seq_err = 1'b0;
    clr_err = 1'b0;
    if (state_reg == ST_FACT_RUN && array_done_i)
    begin
      state_next = ST_IDLE;
      rmode_next = RM_STATUS;
    end
    else if (cmd_take)
    begin
      // address is not decoded for commands
      case (state_reg)
        ST_IDLE:
        begin
          if (busy_reg)
          begin
            if (code == CMD_READ_STATUS)
            begin
              rmode_next = RM_STATUS;
            end
          end
          else
          begin
            case (code)
              CMD_READ_ARRAY: rmode_next = RM_ARRAY;
              CMD_READ_STATUS: rmode_next = RM_STATUS;
              CMD_READ_ID: rmode_next = RM_ID;
              CMD_READ_QUERY: rmode_next = RM_QUERY;
              CMD_CLEAR_STATUS: clr_err = 1'b1;
              CMD_WORD_PROGRAM:
              begin
                state_next = ST_WORD_DATA;
                rmode_next = RM_STATUS;
              end
              CMD_BUF_PROGRAM:
              begin
                state_next = ST_BUF_COUNT;
                rmode_next = RM_STATUS;
              end
              CMD_FACTORY_SETUP:
              begin
                state_next = ST_FACT_CONFIRM;
                rmode_next = RM_STATUS;
              end
              default: state_next = ST_IDLE;
            endcase
          end
        end
        ST_WORD_DATA:
        begin
          push_en = 1'b1;
          push_op = OP_WORD;
          set_busy = 1'b1;
          state_next = ST_IDLE;
        end
        ST_BUF_COUNT:
        begin
          // the word holds the number of words less one
          if (pend_data_reg < BUF_MAX_WORDS)
          begin
            buf_cnt_next = pend_data_reg[BUF_CNT_W-1:0];
            state_next = ST_BUF_DATA;
          end
          else
          begin
            seq_err = 1'b1;
            state_next = ST_IDLE;
          end
        end
        ST_BUF_DATA:
        begin
          push_en = 1'b1;
          push_op = OP_BUF_LOAD;
          buf_cnt_next = BUF_CNT_W'(buf_cnt_reg - 1'b1);
          if (buf_cnt_reg == '0)
          begin
            state_next = ST_BUF_CONFIRM;
          end
        end
        ST_BUF_CONFIRM:
        begin
          state_next = ST_IDLE;
          if (code == CMD_CONFIRM)
          begin
            push_en = 1'b1;
            push_op = OP_BUF_GO;
            set_busy = 1'b1;
          end
          else
          begin
            seq_err = 1'b1;
          end
        end
        ST_FACT_CONFIRM:
        begin
          if (code == CMD_CONFIRM)
          begin
            push_en = 1'b1;
            push_op = OP_FACTORY;
            set_busy = 1'b1;
            state_next = ST_FACT_RUN;
          end
          else
          begin
            seq_err = 1'b1;
            state_next = ST_IDLE;
          end
        end
        ST_FACT_RUN:
        begin
          // every write is a data word, never a command
          push_en = 1'b1;
          push_op = OP_FACTORY;
        end
        default: state_next = ST_IDLE;
      endcase
      if (seq_err)
      begin
        rmode_next = RM_STATUS;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || !pin_rst_n)
    begin
      state_reg <= ST_IDLE;
      rmode_reg <= RM_ARRAY;
      buf_cnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      rmode_reg <= rmode_next;
      buf_cnt_reg <= buf_cnt_next;
    end
  end

  // ****************************************
  // status register
  // ****************************************
  logic prog_err_reg;
  logic erase_err_reg;
  logic [7:0] status_byte;

  // chip select has no say here, so work runs on while deselected
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || !pin_rst_n)
    begin
      busy_reg <= 1'b0;
    end
    else if (set_busy)
    begin
      busy_reg <= 1'b1;
    end
    else if (array_done_i)
    begin
      busy_reg <= 1'b0;
    end
  end

  // a setting event wins over a clear in the same cycle
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || !pin_rst_n)
    begin
      prog_err_reg <= 1'b0;
      erase_err_reg <= 1'b0;
    end
    else
    begin
      if (seq_err || array_error_i)
      begin
        prog_err_reg <= 1'b1;
      end
      else if (clr_err)
      begin
        prog_err_reg <= 1'b0;
      end
      if (seq_err)
      begin
        erase_err_reg <= 1'b1;
      end
      else if (clr_err)
      begin
        erase_err_reg <= 1'b0;
      end
    end
  end

  always_comb
  begin
    status_byte = '0;
    status_byte[SR_READY_POS] = !busy_reg;
    status_byte[SR_ERASE_ERR_POS] = erase_err_reg;
    status_byte[SR_PROG_ERR_POS] = prog_err_reg;
  end

  // ****************************************
  // program path buffer
  // ****************************************
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [ENT_W-1:0] fifo_out_data;

  nfc_fifo #(
    .WIDTH(ENT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(!pin_rst_n),
    .in_valid_i(push_en),
    .in_ready_o(fifo_in_ready),
    .in_data_i({push_op, pend_addr_reg, pend_data_reg}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  assign fifo_out_ready = !prog_valid_o || prog_ready_i;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || !pin_rst_n)
    begin
      prog_valid_o <= 1'b0;
      prog_op_o <= OP_WORD;
      prog_addr_o <= '0;
      prog_data_o <= '0;
    end
    else if (fifo_out_ready)
    begin
      prog_valid_o <= fifo_out_valid;
      if (fifo_out_valid)
      begin
        {prog_op_o, prog_addr_o, prog_data_o} <= fifo_out_data;
      end
    end
  end

  // ****************************************
  // read data and output drivers
  // ****************************************
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      dq_oe_o <= 1'b0;
      dq_o <= '0;
      array_addr_o <= '0;
      array_abort_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      dq_oe_o <= pin_rst_n && !ce_n && !oe_n && we_n;
      array_abort_o <= !pin_rst_n;
      busy_o <= busy_reg;
      array_addr_o <= addr_s;
      case (rmode_reg)
        RM_ARRAY: dq_o <= array_rdata_i;
        RM_STATUS: dq_o <= {8'h00, status_byte};
        RM_ID: dq_o <= id_rdata_i;
        RM_QUERY: dq_o <= {8'h00, query_rdata_i};
        default: dq_o <= '0;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_DESELECT_HIZ: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_n |=> !dq_oe_o) else $error("data driven while deselected");
  AST_DESELECT_KEEPS_BUSY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    busy_reg && ce_n && pin_rst_n && !array_done_i |=> busy_reg)
    else $error("deselect stopped operation");
  AST_RESET_STATE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !pin_rst_n |=> status_byte == STATUS_RESET && rmode_reg == RM_ARRAY && state_reg == ST_IDLE)
    else $error("reset state wrong");
  AST_RESET_ABORT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rst_n_i && !pin_rst_n |=> !dq_oe_o && array_abort_o && !prog_valid_o)
    else $error("reset did not abort and float");
  AST_READ_ARRAY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_take && state_reg == ST_IDLE && !busy_reg && code == CMD_READ_ARRAY
    |=> rmode_reg == RM_ARRAY ##1 dq_o == $past(array_rdata_i))
    else $error("read array not selected");
  AST_PROGRAM_STATUS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_take && state_reg == ST_IDLE && !busy_reg
    && (code == CMD_WORD_PROGRAM || code == CMD_BUF_PROGRAM)
    |=> rmode_reg == RM_STATUS) else $error("program did not select status");
  AST_CLEAR_ERRORS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_take && state_reg == ST_IDLE && !busy_reg && code == CMD_CLEAR_STATUS && !array_error_i
    |=> !prog_err_reg && !erase_err_reg) else $error("errors not cleared");
  AST_WORD_PUSH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_take && state_reg == ST_WORD_DATA
    |-> push_en && push_op == OP_WORD ##1 busy_reg && state_reg == ST_IDLE)
    else $error("word program not started");
  AST_BUSY_IGNORES: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_take && state_reg == ST_IDLE && busy_reg && code != CMD_READ_STATUS
    |=> $stable(rmode_reg) && state_reg == ST_IDLE) else $error("busy accepted command");
  AST_BUF_LIMIT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_take && state_reg == ST_BUF_COUNT && pend_data_reg >= BUF_MAX_WORDS
    |=> state_reg == ST_IDLE && erase_err_reg && prog_err_reg)
    else $error("oversize buffer accepted");
  AST_BUF_CONFIRM: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_take && state_reg == ST_BUF_CONFIRM && code == CMD_CONFIRM
    |-> push_en && push_op == OP_BUF_GO) else $error("buffer confirm lost");
  AST_FACT_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg == ST_FACT_RUN && pin_rst_n && !array_done_i |=> state_reg == ST_FACT_RUN)
    else $error("factory mode left early");
  AST_FACT_CONFIRM: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_take && state_reg == ST_FACT_CONFIRM && code == CMD_CONFIRM
    |-> push_en && push_op == OP_FACTORY ##1 state_reg == ST_FACT_RUN)
    else $error("factory confirm lost");
  AST_SEQ_ERROR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_take && (state_reg == ST_BUF_CONFIRM || state_reg == ST_FACT_CONFIRM)
    && code != CMD_CONFIRM
    |=> prog_err_reg && erase_err_reg && rmode_reg == RM_STATUS)
    else $error("sequence error not flagged");
  AST_WRITE_CAPTURE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_end && !pend_valid_reg && pin_rst_n
    |=> pend_valid_reg && pend_data_reg == $past(cap_data_reg))
    else $error("write not captured");
endmodule
`default_nettype wire

// File: design/nfc_pkg.sv
// constants and types shared by the flash command front end
`default_nettype none
package nfc_pkg;
  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_WORD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_BUF_PROGRAM = 8'hE8;
  localparam logic [7:0] CMD_FACTORY_SETUP = 8'h80;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  // ****************************************
  // status register
  // ****************************************
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam int SR_READY_POS = 7;
  localparam int SR_ERASE_ERR_POS = 5;
  localparam int SR_PROG_ERR_POS = 4;
  // ****************************************
  // widths and counts
  // ****************************************
  localparam int DQ_W = 16;
  localparam int OP_W = 2;
  localparam int BUF_CNT_W = 9;
  localparam logic [15:0] BUF_MAX_WORDS = 16'h0200;
  localparam int SYNC_STAGES = 2;
  localparam int FIFO_DEPTH = 4;
  // ****************************************
  // operations passed to the array programmer
  // ****************************************
  localparam logic [1:0] OP_WORD = 2'h0;
  localparam logic [1:0] OP_BUF_LOAD = 2'h1;
  localparam logic [1:0] OP_BUF_GO = 2'h2;
  localparam logic [1:0] OP_FACTORY = 2'h3;
  // ****************************************
  // state machines
  // ****************************************
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_WORD_DATA = 7'h02,
    ST_BUF_COUNT = 7'h04,
    ST_BUF_DATA = 7'h08,
    ST_BUF_CONFIRM = 7'h10,
    ST_FACT_CONFIRM = 7'h20,
    ST_FACT_RUN = 7'h40
  } nfc_state_t;
  typedef enum logic [3:0] {
    RM_ARRAY = 4'h1,
    RM_STATUS = 4'h2,
    RM_ID = 4'h4,
    RM_QUERY = 4'h8
  } nfc_rmode_t;
endpackage
`default_nettype wire
